// file: rtl/mqrc_top.sv
// Master reset capture and configuration loader of a multi-queue buffer
`timescale 1ns/1ns
`include "mqrc_defs.svh"
module mqrc_top #(
   parameter int TOTAL_DEPTH = 4096
) (
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire logic                  masterResetN,
   input  wire logic                  packetModeSel,
   input  wire logic                  flagBusModeSel,
   input  wire logic [3:0]            portWidthMatch,
   input  wire logic                  primaryDeviceSel,
   input  wire logic [2:0]            chainPositionId,
   input  wire logic                  configSourceSel,
   input  wire logic                  thresholdOffsetSel,
   input  wire logic [1:0]            queueProgSelect,
   input  wire logic                  serialClk,
   input  wire logic                  serialDataIn,
   input  wire logic                  serialEnableInN,
   input  wire logic [2:0]            wrQueueAddr,
   input  wire logic [2:0]            rdQueueAddr,
   input  wire logic                  wrReq,
   input  wire logic                  rdReq,
   input  wire logic [7:0]            regAddr,
   input  wire logic [31:0]           regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic      [31:0]           regRdata,
   output logic                       serialEnableOutN,
   output logic                       serialDataOut,
   output logic                       configDone,
   output logic                       wrAccept,
   output logic                       rdAccept,
   output logic      [1:0]            inWidthCode,
   output logic      [1:0]            outWidthCode,
   output mqrc_pkg::mqrc_straps_t     strapsOut
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [`MQRC_PIN_W-1:0] pinS1;
   logic [`MQRC_PIN_W-1:0] pinS2;
   logic                   mrsS3;
   logic                   sclkS3;
   mqrc_pkg::mqrc_straps_t strapPins;
   logic                   mrsSync;
   logic                   sclkSync;
   logic                   siSync;
   logic                   seniSync;
   logic [2:0]             wrAddrSync;
   logic [2:0]             rdAddrSync;
   logic                   mrsRise;
   logic                   serialBit;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         // Idle levels: master reset and enable high, so no false edge follows reset
         pinS1  <= 24'h900000;
         pinS2  <= 24'h900000;
         mrsS3  <= 1'b1;
         sclkS3 <= 1'b0;
      end
      else
      begin
         pinS1  <= {masterResetN, serialClk, serialDataIn, serialEnableInN,
                    packetModeSel, flagBusModeSel, portWidthMatch, primaryDeviceSel,
                    chainPositionId, configSourceSel, thresholdOffsetSel,
                    queueProgSelect, wrQueueAddr, rdQueueAddr};
         pinS2  <= pinS1;
         mrsS3  <= pinS2[23];
         sclkS3 <= pinS2[22];
      end
   end

   assign mrsSync    = pinS2[23];
   assign sclkSync   = pinS2[22];
   assign siSync     = pinS2[21];
   assign seniSync   = pinS2[20];
   assign strapPins  = pinS2[19:6];
   assign wrAddrSync = pinS2[5:3];
   assign rdAddrSync = pinS2[2:0];
   assign mrsRise    = mrsSync & ~mrsS3;
   // Serial bits count only on a rising serial clock with enable low
   assign serialBit  = sclkSync & ~sclkS3 & ~seniSync;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] depthShare(input logic [3:0] count);
      logic [31:0] total;
      total = 32'(TOTAL_DEPTH);
      case (count)
         4'h1:    depthShare = total[23:0];
         4'h2:    depthShare = total[24:1];
         4'h4:    depthShare = total[25:2];
         4'h8:    depthShare = total[26:3];
         4'h0:    depthShare = 24'h000000;
         default: depthShare = 24'((total / 32'(count)));
      endcase
   endfunction

   // Width code per port: 0 -> 9, 1 -> 18, 2/3 -> 36 bits
   function automatic logic [1:0] widthCode(input logic [1:0] bits);
      widthCode = (bits == 2'h3) ? 2'h2 : bits;
   endfunction

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   mqrc_pkg::mqrc_straps_t straps_q;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         straps_q <= '0;
      end
      else if (mrsRise)
      begin
         straps_q <= strapPins;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         strapsOut    <= '0;
         inWidthCode  <= 2'h0;
         outWidthCode <= 2'h0;
      end
      else
      begin
         strapsOut    <= straps_q;
         inWidthCode  <= widthCode(straps_q.portWidthMatch[1:0]);
         outWidthCode <= widthCode(straps_q.portWidthMatch[3:2]);
      end
   end

   // ----------------------------------------------------------------
   // Configuration sequencer
   // ----------------------------------------------------------------
   mqrc_pkg::mqrc_state_t        state_q;
   logic [`MQRC_QIDX_W-1:0]      qIdx_q;
   logic [3:0]                   qCount_q;
   logic [`MQRC_BITCNT_W-1:0]    bitCnt_q;
   logic                         inHeader_q;
   logic [`MQRC_QUEUE_BITS-1:0]  shift_q;
   logic                         memWe_q;
   logic [`MQRC_QIDX_W-1:0]      memWaddr_q;
   mqrc_pkg::mqrc_entry_t        memWdata_q;
   logic [23:0]                  defOfs;
   logic [3:0]                   defCount;
   logic [`MQRC_QUEUE_BITS-1:0]  shiftNext;

   assign defOfs    = straps_q.thresholdOffset ? `MQRC_OFS_HIGH : `MQRC_OFS_LOW;
   assign shiftNext = {shift_q[`MQRC_QUEUE_BITS-2:0], siSync};

   always_comb
   begin
      case (straps_q.queueProgSelect)
         `MQRC_QUEUE_PROG_SELECT_WRADDR: defCount = {1'b0, wrAddrSync} + 4'h1;
         `MQRC_QUEUE_PROG_SELECT_RDADDR: defCount = {1'b0, rdAddrSync} + 4'h1;
         `MQRC_QUEUE_PROG_SELECT_FOUR:   defCount = 4'h4;
         default:           defCount = 4'h8;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q    <= mqrc_pkg::ST_RESET;
         qIdx_q     <= '0;
         qCount_q   <= 4'h0;
         bitCnt_q   <= '0;
         inHeader_q <= 1'b1;
         shift_q    <= '0;
         memWe_q    <= 1'b0;
         memWaddr_q <= '0;
         memWdata_q <= '0;
      end
      else if (!mrsSync)
      begin
         // Reset pulse restarts the sequencer and wipes one entry per cycle it is held
         state_q    <= mqrc_pkg::ST_RESET;
         qIdx_q     <= qIdx_q + 3'h1;
         qCount_q   <= 4'h0;
         bitCnt_q   <= '0;
         inHeader_q <= 1'b1;
         memWe_q    <= 1'b1;
         memWaddr_q <= qIdx_q;
         memWdata_q <= '0;
      end
      else
      begin
         memWe_q <= 1'b0;
         case (state_q)
            mqrc_pkg::ST_RESET:
            begin
               if (mrsRise)
               begin
                  state_q <= mqrc_pkg::ST_CLEAR;
                  qIdx_q  <= '0;
               end
            end
            mqrc_pkg::ST_CLEAR:
            begin
               // Short reset pulses may not have wiped every entry
               memWe_q    <= 1'b1;
               memWaddr_q <= qIdx_q;
               memWdata_q <= '0;
               qIdx_q     <= qIdx_q + 3'h1;
               if (qIdx_q == 3'h7)
               begin
                  if (straps_q.configSource)
                  begin
                     state_q  <= mqrc_pkg::ST_DEFAULT;
                     qCount_q <= defCount;
                  end
                  else if (straps_q.queueProgSelect == `MQRC_QUEUE_PROG_SELECT_EIGHT)
                  begin
                     state_q <= mqrc_pkg::ST_SERIAL;
                  end
                  else
                  begin
                     state_q <= mqrc_pkg::ST_FAIL;
                  end
               end
            end
            mqrc_pkg::ST_DEFAULT:
            begin
               memWaddr_q <= qIdx_q;
               memWe_q    <= 1'b1;
               if ({1'b0, qIdx_q} < qCount_q)
               begin
                  memWdata_q.depth    <= depthShare(qCount_q);
                  memWdata_q.aeOffset <= defOfs;
                  memWdata_q.afOffset <= defOfs;
               end
               else
               begin
                  memWdata_q <= '0;
               end
               qIdx_q <= qIdx_q + 3'h1;
               if (qIdx_q == 3'h7)
               begin
                  state_q <= mqrc_pkg::ST_DONE;
               end
            end
            mqrc_pkg::ST_SERIAL:
            begin
               if (serialBit)
               begin
                  shift_q  <= shiftNext;
                  bitCnt_q <= bitCnt_q + 7'h01;
                  if (inHeader_q && bitCnt_q == 7'(`MQRC_HDR_BITS - 1))
                  begin
                     // Header low bits carry queue count minus one
                     qCount_q   <= {1'b0, shiftNext[2:0]} + 4'h1;
                     inHeader_q <= 1'b0;
                     bitCnt_q   <= '0;
                     qIdx_q     <= '0;
                  end
                  else if (!inHeader_q && bitCnt_q == 7'(`MQRC_QUEUE_BITS - 1))
                  begin
                     memWe_q    <= 1'b1;
                     memWaddr_q <= qIdx_q;
                     memWdata_q <= shiftNext;
                     bitCnt_q   <= '0;
                     qIdx_q     <= qIdx_q + 3'h1;
                     if ({1'b0, qIdx_q} == qCount_q - 4'h1)
                     begin
                        state_q <= mqrc_pkg::ST_DONE;
                     end
                  end
               end
            end
            default:
            begin
               // Reserved select and finished states hold until next reset
               state_q <= state_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Completion signalling and queue access gate
   // ----------------------------------------------------------------
   logic done;

   assign done = (state_q == mqrc_pkg::ST_DONE);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         serialEnableOutN <= 1'b1;
         serialDataOut    <= 1'b0;
         configDone       <= 1'b0;
         wrAccept         <= 1'b0;
         rdAccept         <= 1'b0;
      end
      else
      begin
         // After completion the serial port passes straight through
         serialEnableOutN <= done ? seniSync : 1'b1;
         serialDataOut    <= done & siSync;
         configDone       <= done;
         wrAccept         <= wrReq & done;
         rdAccept         <= rdReq & done;
      end
   end

   // ----------------------------------------------------------------
   // Setup memory and register port
   // ----------------------------------------------------------------
   logic [`MQRC_QIDX_W-1:0] regIdx_q;
   mqrc_pkg::mqrc_entry_t   memRd;

   mqrc_setup_mem #(
      .WIDTH ($bits(mqrc_pkg::mqrc_entry_t)),
      .DEPTH (`MQRC_MAX_QUEUES),
      .AW    (`MQRC_QIDX_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .wrEn    (memWe_q),
      .wrAddr  (memWaddr_q),
      .wrData  (memWdata_q),
      .rdAddr  (regIdx_q),
      .rdData  (memRd)
   );

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         regIdx_q <= '0;
      end
      else if (regWr && regAddr == `MQRC_REG_QINDEX)
      begin
         regIdx_q <= regWdata[2:0];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         regRdata <= 32'h00000000;
      end
      else if (regRd)
      begin
         if (regAddr == `MQRC_REG_STATUS)
         begin
            regRdata <= '0;
            regRdata[`MQRC_ST_DONE]   <= done;
            regRdata[`MQRC_ST_FAIL]   <= (state_q == mqrc_pkg::ST_FAIL);
            regRdata[`MQRC_ST_SERIAL] <= ~straps_q.configSource;
            regRdata[`MQRC_ST_QCNT_MSB:`MQRC_ST_QCNT_LSB] <= qCount_q;
         end
         else if (regAddr == `MQRC_REG_STRAPS)
         begin
            regRdata <= {18'h0, straps_q};
         end
         else if (regAddr == `MQRC_REG_QINDEX)
         begin
            regRdata <= {29'h0, regIdx_q};
         end
         else if (regAddr == `MQRC_REG_QDEPTH)
         begin
            regRdata <= {8'h00, memRd.depth};
         end
         else if (regAddr == `MQRC_REG_QAEOFS)
         begin
            regRdata <= {8'h00, memRd.aeOffset};
         end
         else if (regAddr == `MQRC_REG_QAFOFS)
         begin
            regRdata <= {8'h00, memRd.afOffset};
         end
         else
         begin
            regRdata <= 32'h00000000;
         end
      end
      else
      begin
         regRdata <= 32'h00000000;
      end
   end

endmodule

// file: rtl/mqrc_defs.svh
// Constants for the multi-queue reset and configuration loader
`ifndef MQRC_DEFS_SVH
`define MQRC_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define MQRC_REG_STATUS     8'h00
`define MQRC_REG_STRAPS     8'h04
`define MQRC_REG_QINDEX     8'h08
`define MQRC_REG_QDEPTH     8'h0c
`define MQRC_REG_QAEOFS     8'h10
`define MQRC_REG_QAFOFS     8'h14

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define MQRC_ST_DONE        0
`define MQRC_ST_FAIL        1
`define MQRC_ST_SERIAL      2
`define MQRC_ST_QCNT_LSB    4
`define MQRC_ST_QCNT_MSB    7

// ----------------------------------------------------------------
// Configuration sizes
// ----------------------------------------------------------------
`define MQRC_MAX_QUEUES     8
`define MQRC_QIDX_W         3
`define MQRC_FIELD_W        24
`define MQRC_HDR_BITS       19
`define MQRC_QUEUE_BITS     72
`define MQRC_BITCNT_W       7
`define MQRC_OFS_LOW        24'h000008
`define MQRC_OFS_HIGH       24'h000080
`define MQRC_STRAP_W        14
`define MQRC_PIN_W          24

// ----------------------------------------------------------------
// Queue programming select codes
// ----------------------------------------------------------------
`define MQRC_QUEUE_PROG_SELECT_WRADDR    2'h0
`define MQRC_QUEUE_PROG_SELECT_RDADDR    2'h1
`define MQRC_QUEUE_PROG_SELECT_FOUR      2'h2
`define MQRC_QUEUE_PROG_SELECT_EIGHT     2'h3

`endif

// file: rtl/mqrc_pkg.sv
// Types shared by the multi-queue reset and configuration loader
package mqrc_pkg;

   typedef struct packed {
      logic       packetMode;
      logic       flagBusMode;
      logic [3:0] portWidthMatch;
      logic       primaryDevice;
      logic [2:0] chainPositionId;
      logic       configSource;
      logic       thresholdOffset;
      logic [1:0] queueProgSelect;
   } mqrc_straps_t;

   typedef struct packed {
      logic [23:0] depth;
      logic [23:0] aeOffset;
      logic [23:0] afOffset;
   } mqrc_entry_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_CLEAR,
      ST_DEFAULT,
      ST_SERIAL,
      ST_FAIL,
      ST_DONE
   } mqrc_state_t;

endpackage

// file: rtl/mqrc_setup_mem.sv
// Per-queue setup memory with registered read data
`timescale 1ns/1ns
module mqrc_setup_mem #(
   parameter int WIDTH = 72,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      rdData <= mem[rdAddr];
   end

endmodule

// file: test/mqrc_checker.sv
// Port-level assertions for the reset and configuration loader
`timescale 1ns/1ns
`include "mqrc_defs.svh"
module mqrc_checker #(
   parameter int TOTAL_DEPTH = 4096
) (
   input wire logic                   clk_sys,
   input wire logic                   resetn,
   input wire logic                   masterResetN,
   input wire logic                   wrReq,
   input wire logic [7:0]             regAddr,
   input wire logic                   regRd,
   input wire logic [31:0]            regRdata,
   input wire logic                   serialEnableOutN,
   input wire logic                   configDone,
   input wire logic                   wrAccept,
   input wire logic                   rdAccept,
   input wire logic [1:0]             inWidthCode,
   input wire logic [1:0]             outWidthCode,
   input wire mqrc_pkg::mqrc_straps_t strapsOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic eightDef;
   // Eight equal default queues: any selected entry has the same contents
   assign eightDef = configDone && strapsOut.configSource && strapsOut.queueProgSelect == 2'h3;
   function automatic logic [1:0] wmap(logic [1:0] m);
      return (m == 2'h3) ? 2'h2 : m;
   endfunction
   property p_senoHold; !configDone |-> serialEnableOutN; endproperty
   a_senoHold: assert property (p_senoHold) else $error("serial_enable_out_n low before done");
   property p_doneSeno; $fell(serialEnableOutN) |-> configDone; endproperty
   a_doneSeno: assert property (p_doneSeno) else $error("serial_enable_out_n fell without done");
   property p_gate; !configDone |-> !wrAccept && !rdAccept; endproperty
   a_gate: assert property (p_gate) else $error("queue op accepted early");
   property p_pass; (configDone && wrReq) ##1 configDone |-> wrAccept; endproperty
   a_pass: assert property (p_pass) else $error("write refused after done");
   property p_hold; configDone && $past(configDone) |-> $stable(strapsOut); endproperty
   a_hold: assert property (p_hold) else $error("latched straps moved");
   property p_width;
      configDone |-> inWidthCode == wmap(strapsOut.portWidthMatch[1:0])
         && outWidthCode == wmap(strapsOut.portWidthMatch[3:2]);
   endproperty
   a_width: assert property (p_width) else $error("width code mismatch");
   property p_select;
      configDone && !strapsOut.configSource |-> strapsOut.queueProgSelect == 2'h3;
   endproperty
   a_select: assert property (p_select) else $error("reserved select completed");
   property p_defOfs;
      eightDef && regRd && regAddr == `MQRC_REG_QAEOFS
         |=> regRdata == (strapsOut.thresholdOffset ? 32'h80 : 32'h8);
   endproperty
   a_defOfs: assert property (p_defOfs) else $error("default offset wrong");
   property p_defDepth;
      eightDef && regRd && regAddr == `MQRC_REG_QDEPTH |=> regRdata == 32'(TOTAL_DEPTH / 8);
   endproperty
   a_defDepth: assert property (p_defDepth) else $error("default depth wrong");
   property p_clear; $fell(masterResetN) ##1 (!masterResetN) [*6] |-> !configDone; endproperty
   a_clear: assert property (p_clear) else $error("done kept in master reset");
   property p_loadTime; $rose(configDone) |-> $past(masterResetN, 16); endproperty
   a_loadTime: assert property (p_loadTime) else $error("done too soon");
   c_done: cover property ($rose(configDone));
   c_accept: cover property (wrAccept);
   c_serial: cover property ($fell(serialEnableOutN) && !strapsOut.configSource);
endmodule

bind mqrc_top mqrc_checker #(.TOTAL_DEPTH(TOTAL_DEPTH)) mqrc_checker_inst (.clk_sys, .resetn,
   .masterResetN, .wrReq, .regAddr, .regRd, .regRdata, .serialEnableOutN, .configDone,
   .wrAccept, .rdAccept, .inWidthCode, .outWidthCode, .strapsOut);

// file: test/mqrc_host_model.sv
// Host controller model driving master reset, strap and serial pins
`timescale 1ns/1ns
module mqrc_host_model (
   input  wire logic             clk_sys,
   output logic                  masterResetN,
   output mqrc_pkg::mqrc_straps_t strapPins,
   output logic                  serialClk,
   output logic                  serialDataIn,
   output logic                  serialEnableInN
);
   initial
   begin
      masterResetN = 1'b1;
      strapPins = '0;
      serialClk = 1'b0;
      serialDataIn = 1'b0;
      serialEnableInN = 1'b1;
   end
   task automatic pulse(input mqrc_pkg::mqrc_straps_t s);
      @(posedge clk_sys);
      strapPins <= s;
      serialEnableInN <= 1'b0;
      repeat (2) @(posedge clk_sys);
      masterResetN <= 1'b0;
      repeat (8) @(posedge clk_sys);
      masterResetN <= 1'b1;
      // Sync, latch and clear pass before serial bits are taken
      repeat (12) @(posedge clk_sys);
   endtask
   task automatic setPins(input mqrc_pkg::mqrc_straps_t s);
      @(posedge clk_sys);
      strapPins <= s;
   endtask
   // Clock stands low between frames; 4 cycles per phase beats the sync
   task automatic shift(input logic [71:0] w, input int n);
      for (int b = n - 1; b >= 0; b--)
      begin
         @(posedge clk_sys);
         serialDataIn <= w[b];
         repeat (4) @(posedge clk_sys);
         serialClk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         serialClk <= 1'b0;
      end
      @(posedge clk_sys);
      serialDataIn <= ~serialDataIn;
   endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the reset and configuration loader
`timescale 1ns/1ns
`include "mqrc_defs.svh"
module tb_top;
   logic                   clk_sys, resetn, masterResetN, serialClk, serialDataIn;
   logic                   serialEnableInN, wrReq, rdReq, regWr, regRd, serialEnableOutN;
   logic                   configDone, wrAccept, rdAccept, thr, serialDataOut;
   logic [2:0]             wrQueueAddr, rdQueueAddr;
   logic [7:0]             regAddr;
   logic [31:0]            regWdata, regRdata, rd;
   logic [1:0]             inWidthCode, outWidthCode;
   mqrc_pkg::mqrc_straps_t strapPins, strapsOut, s;
   int                     compares, miscompares;
   int                     expQ [4] = '{3, 6, 4, 8};
   always #5 clk_sys = ~clk_sys;
   mqrc_host_model mqrc_host_model_inst (.clk_sys(clk_sys), .masterResetN(masterResetN),
      .strapPins(strapPins), .serialClk(serialClk), .serialDataIn(serialDataIn),
      .serialEnableInN(serialEnableInN));
   mqrc_top #(.TOTAL_DEPTH(4096)) mqrc_top_inst (.clk_sys(clk_sys), .resetn(resetn),
      .masterResetN(masterResetN), .packetModeSel(strapPins.packetMode),
      .flagBusModeSel(strapPins.flagBusMode), .portWidthMatch(strapPins.portWidthMatch),
      .primaryDeviceSel(strapPins.primaryDevice), .chainPositionId(strapPins.chainPositionId),
      .configSourceSel(strapPins.configSource), .thresholdOffsetSel(strapPins.thresholdOffset),
      .queueProgSelect(strapPins.queueProgSelect), .serialClk(serialClk),
      .serialDataIn(serialDataIn), .serialEnableInN(serialEnableInN),
      .wrQueueAddr(wrQueueAddr), .rdQueueAddr(rdQueueAddr), .wrReq(wrReq), .rdReq(rdReq),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .serialEnableOutN(serialEnableOutN), .serialDataOut(serialDataOut),
      .configDone(configDone), .wrAccept(wrAccept), .rdAccept(rdAccept),
      .inWidthCode(inWidthCode), .outWidthCode(outWidthCode), .strapsOut(strapsOut));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic readCheck(input logic [7:0] a, input string what, input logic [31:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 rd = regRdata;
      check(what, rd, exp);
   endtask
   task automatic results;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic waitDone(input int bound);
      for (int n = 0; n < bound && configDone !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check("configDone", configDone, 1);
      if (configDone !== 1'b1)
         results();
   endtask
   initial
   begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      {wrQueueAddr, rdQueueAddr} = {3'h2, 3'h5};
      {wrReq, rdReq, regWr, regRd, regAddr, regWdata} = '0;
      {compares, miscompares} = '0;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      wrReq <= 1'b1;
      rdReq <= 1'b1;
      @(posedge clk_sys);
      #1 check("serial_enable_out_n", serialEnableOutN, 1);
      // ----------
      // Default loads, all four selects
      // ----------
      for (int i = 0; i < 4; i++)
      begin
         thr = (i == 1 || i == 2);
         s = {i[0], ~i[0], 4'(i * 5), 1'b1, 3'(i), 1'b1, thr, 2'(i)};
         mqrc_host_model_inst.pulse(s);
         #1 check("wrAccept", wrAccept, 0);
         check("rdAccept", rdAccept, 0);
         check("serial_enable_out_n", serialEnableOutN, 1);
         waitDone(200);
         check("wrAccept", wrAccept, 1);
         check("rdAccept", rdAccept, 1);
         check("serial_enable_out_n", serialEnableOutN, 0);
         check("straps", strapsOut, s);
         check("inWidth", inWidthCode, (i == 3) ? 2 : i);
         check("outWidth", outWidthCode, (i == 3) ? 2 : i);
         readCheck(`MQRC_REG_STATUS, "status", 32'(expQ[i] * 16 + 1));
         regWrite(`MQRC_REG_QINDEX, 32'(expQ[i] - 1));
         readCheck(`MQRC_REG_QDEPTH, "depth", 32'(4096 / expQ[i]));
         readCheck(`MQRC_REG_QAEOFS, "aeOffset", thr ? 32'h80 : 32'h8);
         readCheck(`MQRC_REG_QAFOFS, "afOffset", thr ? 32'h80 : 32'h8);
         mqrc_host_model_inst.setPins(~s);
         repeat (4) @(posedge clk_sys);
         #1 check("strapsHeld", strapsOut, s);
         $display("test default %0d done", i);
      end
      readCheck(8'h18, "unmapped", 32'h0);
      // Reserved select with serial source must never complete
      mqrc_host_model_inst.pulse({8'h01, 4'h0, 2'h1});
      repeat (40) @(posedge clk_sys);
      #1 check("failDone", configDone, 0);
      check("serial_enable_out_n", serialEnableOutN, 1);
      readCheck(`MQRC_REG_STATUS, "status", 32'h6);
      $display("test reserved done");
      mqrc_host_model_inst.pulse({8'h01, 4'h0, 2'h3});
      mqrc_host_model_inst.shift(72'h1, 19);
      #1 check("earlyDone", configDone, 0);
      mqrc_host_model_inst.shift({24'h100, 24'h11, 24'h22}, 72);
      mqrc_host_model_inst.shift({24'h300, 24'h33, 24'h44}, 72);
      waitDone(50);
      check("serial_enable_out_n", serialEnableOutN, 0);
      readCheck(`MQRC_REG_STATUS, "status", 32'h25);
      regWrite(`MQRC_REG_QINDEX, 32'h1);
      readCheck(`MQRC_REG_QDEPTH, "depth1", 32'h300);
      readCheck(`MQRC_REG_QAEOFS, "ae1", 32'h33);
      readCheck(`MQRC_REG_QAFOFS, "af1", 32'h44);
      regWrite(`MQRC_REG_QINDEX, 32'h0);
      readCheck(`MQRC_REG_QDEPTH, "depth0", 32'h100);
      check("serialOut", serialDataOut, serialDataIn);
      $display("test serial done");
      results();
   end
endmodule
